// [rtl/nco_mixer_device.sv]
// two-channel oscillator bank and complex mixer with hop selection and sync
// assumes hop pins, sync and sysref are asynchronous; config port is on mclk
//
// Contract
// - 32-bit tuning word sets each oscillator frequency
// - real samples times selected complex exponential
// - four oscillators per channel, own word and offset
// - unselected accumulators keep running
// - hop pins switch asynchronously, fixed latency
// - source bit 1: pins pick oscillator
// - source bit 0 default: register field picks
// - divider zero: plain binary accumulator wrap
// - word rewrite leaves phase undefined until resync
// - rational mode wraps every divider times 64
// - controller keeps divider at or below 8192; the controller only flags larger divider writes in its status
// - controller computes word from step count; here software writes the word and the controller forwards it
// - 16-bit offset added in top accumulator bits
// - sync by link init or next sysref
// - link-init sync needs enable bit and link
// - sync rising edge resynchronises all oscillators
// - single sysref pulse resyncs when armed
// - armed: next sysref rising edge resyncs
// - controller times arming between sysref edges; here software arms, and the controller only sets the sysref period
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module nco_mixer_device #(
    parameter int HOP_DELAY = nco_pkg::HOP_LAT,
    parameter int ADC_DELAY = nco_pkg::ADC_LAT
) (
    // clock and reset
    input  wire logic                                           mclk,
    input  wire logic                                           reset_n,
    // pins and config port
    nco_link_if.device                                          link,
    // converter samples
    input  wire logic [nco_pkg::NUM_CH-1:0][nco_pkg::SMP_W-1:0] sampleIn,
    // mixer output
    output logic      [nco_pkg::NUM_CH-1:0][nco_pkg::MIX_W-1:0] mixI,
    output logic      [nco_pkg::NUM_CH-1:0][nco_pkg::MIX_W-1:0] mixQ,
    output logic      [nco_pkg::NUM_CH-1:0][1:0]                activeSel
);
    import nco_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] hopS1 [NUM_CH];
    logic [1:0] hopS2 [NUM_CH];
    logic [1:0] hopLine [NUM_CH][HOP_DELAY];
    logic [1:0] evS1;
    logic [1:0] evS2;
    logic [1:0] evS3;
    wire  [1:0] hopPin [NUM_CH];
    assign hopPin[0] = link.hopSelA;
    assign hopPin[1] = link.hopSelB;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            evS1 <= 2'h0;
            evS2 <= 2'h0;
            evS3 <= 2'h0;
        end else begin
            evS1 <= {link.sysref, link.linkSync};
            evS2 <= evS1;
            evS3 <= evS2;
        end
    end

    // the hop line stands in for the pin-to-mixer pipeline so switching latency is fixed
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int c = 0; c < NUM_CH; c++) begin
                hopS1[c] <= 2'h0;
                hopS2[c] <= 2'h0;
                for (int d = 0; d < HOP_DELAY; d++) hopLine[c][d] <= 2'h0;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                hopS1[c]      <= hopPin[c];
                hopS2[c]      <= hopS1[c];
                hopLine[c][0] <= hopS2[c];
                for (int d = 1; d < HOP_DELAY; d++) hopLine[c][d] <= hopLine[c][d-1];
            end
        end
    end

    // ************************************************************
    // sync events
    // ************************************************************
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    wire syncRise  = evS2[0] & ~evS3[0];
    wire srefRise  = evS2[1] & ~evS3[1];
    // the link must be enabled so the rise before link enable is not taken
    wire ilaEvent  = ctrl_reg[CTRL_ILA] & ctrl_reg[CTRL_LINK] & syncRise;
    wire nextEvent = ctrl_reg[CTRL_NEXT] & srefRise;
    wire resync    = ilaEvent | nextEvent;

    // ************************************************************
    // configuration writes
    // ************************************************************
    wire        cfgWr    = link.cfgReq & link.cfgWe;
    wire        wrCtrl   = cfgWr && link.cfgAddr == CFG_CTRL;
    wire        wrRdiv   = cfgWr && link.cfgAddr == CFG_RDIV;
    wire        isTune   = link.cfgAddr[7:3] == CFG_TUNE_BASE[7:3];
    wire        isPhase  = link.cfgAddr[7:3] == CFG_PHASE_BASE[7:3];
    wire        cfgCh    = link.cfgAddr[2];
    wire [1:0]  cfgOsc   = link.cfgAddr[1:0];

    logic [RDIV_W-1:0] rdiv_reg;
    logic [TW_W-1:0]   tune_reg  [NUM_CH][NUM_OSC];
    logic [PH_W-1:0]   phase_reg [NUM_CH][NUM_OSC];
    logic [TW_W-1:0]   acc_reg   [NUM_CH][NUM_OSC];
    logic [RAT_W-1:0]  ratCnt_reg;
    logic [7:0]        syncCnt_reg;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (ilaEvent) ctrl_next[CTRL_ILA] = 1'b0;
        if (nextEvent) ctrl_next[CTRL_NEXT] = 1'b0;
        // a software write in the same cycle keeps its own value
        if (wrCtrl) ctrl_next = link.cfgWdata[7:0];
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg    <= CTRL_RST;
            rdiv_reg    <= '0;
            syncCnt_reg <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            if (wrRdiv) rdiv_reg <= link.cfgWdata[RDIV_W-1:0];
            if (resync) syncCnt_reg <= syncCnt_reg + 8'h01;
        end
    end

    // ************************************************************
    // rational wrap counter
    // ************************************************************
    wire             ratMode = rdiv_reg != '0;
    wire [RAT_W-1:0] ratLast = {rdiv_reg, {RAT_SHIFT{1'b0}}} - {{(RAT_W-1){1'b0}}, 1'b1};
    // after divider*64 clocks every rational frequency has done whole turns,
    // so clearing the phase there removes the word's rounding error
    wire             ratWrap = ratMode && ratCnt_reg == ratLast;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ratCnt_reg <= '0;
        end else if (resync || ratWrap || !ratMode) begin
            ratCnt_reg <= '0;
        end else begin
            ratCnt_reg <= ratCnt_reg + {{(RAT_W-1){1'b0}}, 1'b1};
        end
    end

    // ************************************************************
    // oscillator bank
    // ************************************************************
    // a word rewritten while running is taken at once without touching the
    // accumulator, so phase is only defined again after the next resync or rational wrap
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int c = 0; c < NUM_CH; c++) begin
                for (int k = 0; k < NUM_OSC; k++) begin
                    tune_reg[c][k]  <= '0;
                    phase_reg[c][k] <= '0;
                    acc_reg[c][k]   <= '0;
                end
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                for (int k = 0; k < NUM_OSC; k++) begin
                    if (cfgWr && isTune && cfgCh == c[0] && cfgOsc == k[1:0])
                        tune_reg[c][k] <= link.cfgWdata;
                    if (cfgWr && isPhase && cfgCh == c[0] && cfgOsc == k[1:0])
                        phase_reg[c][k] <= link.cfgWdata[PH_W-1:0];
                    if (resync || ratWrap)
                        acc_reg[c][k] <= '0;
                    else
                        acc_reg[c][k] <= acc_reg[c][k] + tune_reg[c][k];
                end
            end
        end
    end

    // ************************************************************
    // selection and mixer
    // ************************************************************
    function automatic logic signed [7:0] sinLut(input logic [5:0] p);
        logic [3:0] idx;
        logic [7:0] mag;
        idx = p[4] ? ~p[3:0] : p[3:0];
        mag = SIN_QTR[idx];
        sinLut = p[5] ? -mag : mag;
    endfunction

    logic [SMP_W-1:0] smpLine [NUM_CH][ADC_DELAY];
    wire  [1:0]       regSel [NUM_CH];
    wire  [1:0]       useSel [NUM_CH];
    wire  [TW_W-1:0]  selPhase [NUM_CH];
    assign regSel[0] = ctrl_reg[CTRL_SELA +: 2];
    assign regSel[1] = ctrl_reg[CTRL_SELB +: 2];

    for (genvar c = 0; c < NUM_CH; c++) begin : g_sel
        assign useSel[c] = ctrl_reg[CTRL_SRC] ? hopLine[c][HOP_DELAY-1]
                                              : regSel[c];
        assign selPhase[c] = acc_reg[c][activeSel[c]]
                           + {phase_reg[c][activeSel[c]], {(TW_W-PH_W){1'b0}}};
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int c = 0; c < NUM_CH; c++) begin
                activeSel[c] <= 2'h0;
                mixI[c]      <= '0;
                mixQ[c]      <= '0;
                for (int d = 0; d < ADC_DELAY; d++) smpLine[c][d] <= '0;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                activeSel[c] <= useSel[c];
                smpLine[c][0] <= sampleIn[c];
                for (int d = 1; d < ADC_DELAY; d++) smpLine[c][d] <= smpLine[c][d-1];
                mixI[c] <= 16'((20'($signed(smpLine[c][ADC_DELAY-1]))
                           * sinLut(selPhase[c][31:26] + 6'h10)) >>> 3);
                mixQ[c] <= 16'((20'($signed(smpLine[c][ADC_DELAY-1]))
                           * sinLut(selPhase[c][31:26])) >>> 3);
            end
        end
    end

    // ************************************************************
    // readback
    // ************************************************************
    logic [CFG_DW-1:0] rd;
    always_comb begin
        rd = '0;
        if (link.cfgAddr == CFG_CTRL) rd[7:0] = ctrl_reg;
        else if (link.cfgAddr == CFG_RDIV) rd[RDIV_W-1:0] = rdiv_reg;
        else if (link.cfgAddr == CFG_STATUS) rd[11:0] = {syncCnt_reg, activeSel[1], activeSel[0]};
        else if (isTune) rd = tune_reg[cfgCh][cfgOsc];
        else if (isPhase) rd[PH_W-1:0] = phase_reg[cfgCh][cfgOsc];
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) link.cfgRdata <= '0;
        else if (link.cfgReq) link.cfgRdata <= rd;
    end

endmodule // nco_mixer_device
`default_nettype wire

// [include/nco_pkg.sv]
// constants shared by the oscillator/mixer device end and its controller end
// assumes a single 40 MHz mclk domain on both ends
package nco_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_CH    = 2;
    localparam int NUM_OSC   = 4;
    localparam int TW_W      = 32;
    localparam int PH_W      = 16;
    localparam int SMP_W     = 12;
    localparam int MIX_W     = 16;
    localparam int RDIV_W    = 16;
    localparam int RAT_SHIFT = 6;             // divider counts blocks of 64 clocks
    localparam int RAT_W     = RDIV_W + RAT_SHIFT;
    localparam int CFG_AW    = 8;
    localparam int CFG_DW    = 32;

    // ************************************************************
    // timing counts in mclk cycles
    // ************************************************************
    localparam int HOP_LAT   = 43;            // plus two synchroniser stages gives 45
    localparam int ADC_LAT   = 37;
    localparam int SREF_HIGH = 4;
    localparam logic [15:0] SREF_PERIOD_DEF = 16'h0400;
    localparam logic [15:0] RDIV_MAX_REC    = 16'h2000;

    // ************************************************************
    // device configuration map (word index)
    // ************************************************************
    localparam logic [7:0] CFG_CTRL       = 8'h00;
    localparam logic [7:0] CFG_RDIV       = 8'h01;
    localparam logic [7:0] CFG_STATUS     = 8'h02;
    localparam logic [7:0] CFG_TUNE_BASE  = 8'h10;   // + ch*4 + osc
    localparam logic [7:0] CFG_PHASE_BASE = 8'h20;   // + ch*4 + osc
    localparam int CTRL_SRC  = 0;
    localparam int CTRL_SELA = 1;             // two bits
    localparam int CTRL_SELB = 3;             // two bits
    localparam int CTRL_ILA  = 5;
    localparam int CTRL_NEXT = 6;
    localparam int CTRL_LINK = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // ************************************************************
    // controller wishbone map
    // ************************************************************
    localparam int WB_HOST_BIT = 10;          // 0: device window, 1: controller registers
    localparam logic [7:0] HOST_PINS   = 8'h00;
    localparam logic [7:0] HOST_LINK   = 8'h01;
    localparam logic [7:0] HOST_SRPER  = 8'h02;
    localparam logic [7:0] HOST_STATUS = 8'h03;
    localparam int LINK_SYNC  = 0;
    localparam int LINK_SRUN  = 1;
    localparam int LINK_SPULS = 2;

    // quarter-wave sine, 16 points, amplitude 127
    localparam logic [15:0][7:0] SIN_QTR = {
        8'h7f, 8'h7e, 8'h7b, 8'h78, 8'h73, 8'h6d, 8'h66, 8'h5e,
        8'h55, 8'h4c, 8'h41, 8'h36, 8'h2b, 8'h1f, 8'h13, 8'h06};

endpackage

// [include/nco_link_if.sv]
// pins between controller and device: hop pins, sync, sysref, config port
// assumes both ends run on the same mclk
`timescale 1ns/1ps
`default_nettype none
interface nco_link_if;
    logic [1:0]                  hopSelA;
    logic [1:0]                  hopSelB;
    logic                        linkSync;
    logic                        sysref;
    logic                        cfgReq;
    logic                        cfgWe;
    logic [nco_pkg::CFG_AW-1:0]  cfgAddr;
    logic [nco_pkg::CFG_DW-1:0]  cfgWdata;
    logic [nco_pkg::CFG_DW-1:0]  cfgRdata;

    modport host (output hopSelA, hopSelB, linkSync, sysref,
                  output cfgReq, cfgWe, cfgAddr, cfgWdata, input cfgRdata);
    modport device (input hopSelA, hopSelB, linkSync, sysref,
                    input cfgReq, cfgWe, cfgAddr, cfgWdata, output cfgRdata);
endinterface
`default_nettype wire

// [rtl/nco_host_ctrl.sv]
// controller end: wishbone slave driving hop pins, sync, sysref and config port
// assumes software on classic wishbone in the same mclk domain as the device
`timescale 1ns/1ps
`default_nettype none
module nco_host_ctrl #(
    parameter logic [15:0] SREF_PERIOD_RST = nco_pkg::SREF_PERIOD_DEF
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // link to device
    nco_link_if.host         link
);
    import nco_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_FWD, H_WAIT} hstate_t;

    // ************************************************************
    // decode
    // ************************************************************
    hstate_t     state_reg;
    logic [3:0]  pins_reg;
    logic [2:0]  linkCtl_reg;
    logic [15:0] srPer_reg;
    logic [15:0] perCnt_reg;
    logic [2:0]  pulseCnt_reg;
    logic        rdivWarn_reg;

    wire       req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & state_reg == H_IDLE;
    wire       hostWin = wb_adr_i[WB_HOST_BIT];
    wire [7:0] idx     = wb_adr_i[9:2];
    // partial writes into the device window are acknowledged but dropped
    wire       fwd     = req & ~hostWin & (~wb_we_i | wb_sel_i == 4'hf);
    wire       local_  = req & ~fwd;
    wire       hWr     = local_ & hostWin & wb_we_i;
    wire       srun    = linkCtl_reg[LINK_SRUN];

    logic [31:0] hostRd;
    always_comb begin
        hostRd = 32'h0000_0000;
        if (hostWin && idx == HOST_PINS) hostRd[3:0] = pins_reg;
        else if (hostWin && idx == HOST_LINK) hostRd[2:0] = linkCtl_reg;
        else if (hostWin && idx == HOST_SRPER) hostRd[15:0] = srPer_reg;
        else if (hostWin && idx == HOST_STATUS) hostRd[0] = rdivWarn_reg;
    end

    // ************************************************************
    // bus handshake and device forwarding
    // ************************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg     <= H_IDLE;
            wb_ack_o      <= 1'b0;
            wb_dat_o      <= 32'h0000_0000;
            link.cfgReq   <= 1'b0;
            link.cfgWe    <= 1'b0;
            link.cfgAddr  <= '0;
            link.cfgWdata <= '0;
        end else begin
            wb_ack_o    <= 1'b0;
            link.cfgReq <= 1'b0;
            case (state_reg)
                H_IDLE: begin
                    if (fwd) begin
                        link.cfgReq   <= 1'b1;
                        link.cfgWe    <= wb_we_i;
                        link.cfgAddr  <= idx;
                        link.cfgWdata <= wb_dat_i;
                        state_reg     <= H_FWD;
                    end else if (local_) begin
                        wb_dat_o <= hostRd;
                        wb_ack_o <= 1'b1;
                    end
                end
                H_FWD: state_reg <= H_WAIT;
                H_WAIT: begin
                    wb_dat_o  <= link.cfgRdata;
                    wb_ack_o  <= 1'b1;
                    state_reg <= H_IDLE;
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end

    // ************************************************************
    // controller registers and pins
    // ************************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pins_reg     <= 4'h0;
            linkCtl_reg  <= 3'h0;
            srPer_reg    <= SREF_PERIOD_RST;
            rdivWarn_reg <= 1'b0;
        end else begin
            if (hWr && idx == HOST_PINS && wb_sel_i[0]) pins_reg <= wb_dat_i[3:0];
            if (hWr && idx == HOST_LINK && wb_sel_i[0]) linkCtl_reg <= wb_dat_i[2:0];
            else linkCtl_reg[LINK_SPULS] <= 1'b0;
            if (hWr && idx == HOST_SRPER && wb_sel_i[0]) srPer_reg[7:0] <= wb_dat_i[7:0];
            if (hWr && idx == HOST_SRPER && wb_sel_i[1]) srPer_reg[15:8] <= wb_dat_i[15:8];
            if (hWr && idx == HOST_STATUS && wb_dat_i[0]) rdivWarn_reg <= 1'b0;
            // flag dividers that hurt spur performance; set wins over clear
            if (fwd && wb_we_i && idx == CFG_RDIV && wb_dat_i[15:0] > RDIV_MAX_REC)
                rdivWarn_reg <= 1'b1;
        end
    end

    // ************************************************************
    // sysref generator
    // ************************************************************
    // a long period leaves software room to arm between two edges
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            perCnt_reg   <= 16'h0000;
            pulseCnt_reg <= 3'h0;
            link.sysref  <= 1'b0;
        end else begin
            if (!srun || perCnt_reg >= srPer_reg - 16'h0001) perCnt_reg <= 16'h0000;
            else perCnt_reg <= perCnt_reg + 16'h0001;
            if (linkCtl_reg[LINK_SPULS] && !srun) pulseCnt_reg <= 3'(SREF_HIGH);
            else if (pulseCnt_reg != 3'h0) pulseCnt_reg <= pulseCnt_reg - 3'h1;
            link.sysref <= srun ? perCnt_reg < 16'(SREF_HIGH) : pulseCnt_reg != 3'h0;
        end
    end

    assign link.hopSelA  = pins_reg[1:0];
    assign link.hopSelB  = pins_reg[3:2];
    assign link.linkSync = linkCtl_reg[LINK_SYNC];

endmodule // nco_host_ctrl
`default_nettype wire

// [test/nco_link_props.sv]
// checker on the pins between controller and oscillator device
// assumes one mclk domain and the device map of nco_pkg
`timescale 1ns/1ps
`default_nettype none
module nco_link_props #(
    parameter int HOP_DELAY = 1
) (
    // clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // link signals
    input wire logic [1:0]  hopSelA,
    input wire logic [1:0]  hopSelB,
    input wire logic        sysref,
    input wire logic        cfgReq,
    input wire logic        cfgWe,
    input wire logic [7:0]  cfgAddr,
    input wire logic [31:0] cfgWdata,
    input wire logic [31:0] cfgRdata
);
    import nco_pkg::*;
    // ************************************************************
    // shadow of written words, indexed by the low six address bits
    // ************************************************************
    logic [31:0] shadow [64];
    logic [7:0]  ctrlShadow;
    logic [7:0]  hopStable;
    wire         rd   = cfgReq && !cfgWe;
    wire         wr   = cfgReq && cfgWe;
    wire         tune = cfgAddr[7:3] == 5'h02;
    wire         phs  = cfgAddr[7:3] == 5'h04;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shadow     <= '{default: '0};
            ctrlShadow <= '0;
            hopStable  <= '0;
        end else begin
            if (wr && (tune || phs || cfgAddr == CFG_RDIV)) shadow[cfgAddr[5:0]] <= cfgWdata;
            if (wr && cfgAddr == CFG_CTRL) ctrlShadow <= cfgWdata[7:0];
            // pins must settle past the synchroniser and line delay
            hopStable <= ($stable(hopSelA) && $stable(hopSelB))
                       ? hopStable + 8'(hopStable != 8'hff) : '0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_sref_width: assert property (
        $rose(sysref) |-> sysref [*4] ##1 !sysref) else $error("sysref pulse width wrong");
    chk_req_single: assert property (
        cfgReq |=> !cfgReq) else $error("config request longer than one cycle");
    chk_rdata_hold: assert property (
        !cfgReq |=> $stable(cfgRdata)) else $error("read data moved without request");
    chk_tune_back: assert property (
        rd && tune |=> cfgRdata == shadow[cfgAddr[5:0]]) else $error("tuning word lost");
    chk_phase_back: assert property (
        rd && phs |=> cfgRdata[15:0] == shadow[cfgAddr[5:0]][15:0])
        else $error("phase offset lost");
    chk_rdiv_back: assert property (
        rd && cfgAddr == CFG_RDIV |=> cfgRdata[15:0] == shadow[1][15:0])
        else $error("divider lost");
    chk_ctrl_back: assert property (
        rd && cfgAddr == CFG_CTRL |=> {cfgRdata[7], cfgRdata[4:0]} ==
        {ctrlShadow[7], ctrlShadow[4:0]}) else $error("control word lost");
    chk_sel_reg: assert property (
        rd && cfgAddr == CFG_STATUS && !ctrlShadow[0] |=> cfgRdata[3:0] ==
        {ctrlShadow[4:3], ctrlShadow[2:1]}) else $error("register selection wrong");
    chk_sel_pins: assert property (
        rd && cfgAddr == CFG_STATUS && ctrlShadow[0] && hopStable > HOP_DELAY + 3
        |=> cfgRdata[3:0] == {hopSelB, hopSelA}) else $error("pin selection wrong");
endmodule // nco_link_props
`default_nettype wire

// [test/nco_mixer_hop_sync_tb_top.sv]
// bench: software reaches both ends through the controller's wishbone slave
// assumes 40 MHz mclk, short hop delay, sysref period 16
`timescale 1ns/1ps
`default_nettype none
module nco_mixer_hop_sync_tb_top;
    import nco_pkg::*;
    localparam int HOP_D = 1;
    logic                         mclk = 1'b0;
    logic                         reset_n = 1'b0;
    logic                         wbCyc = 1'b0;
    logic                         wbWe = 1'b0;
    logic [31:0]                  wbAdr = '0;
    logic [31:0]                  wbDatW = '0;
    logic [31:0]                  wbDatR;
    logic                         wbAck;
    logic [NUM_CH-1:0][SMP_W-1:0] sampleIn = '0;
    logic [NUM_CH-1:0][MIX_W-1:0] mixI;
    logic [NUM_CH-1:0][MIX_W-1:0] mixQ;
    logic [NUM_CH-1:0][1:0]       activeSel;
    int                           errorCnt = 0;
    int                           totalChecks = 0;
    int                           seed = 32'hfadd;
    logic [63:0]                  noteQ [$];
    logic [31:0]                  tw [16];
    logic signed [SMP_W-1:0]      smpD [2];
    nco_link_if lnk ();
    nco_host_ctrl #(.SREF_PERIOD_RST(16'h0010)) i_nco_host_ctrl (.mclk(mclk), .reset_n(reset_n),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbCyc), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .link(lnk));
    nco_mixer_device #(.HOP_DELAY(HOP_D), .ADC_DELAY(1)) i_nco_mixer_device (.mclk(mclk),
        .reset_n(reset_n), .link(lnk), .sampleIn(sampleIn), .mixI(mixI), .mixQ(mixQ),
        .activeSel(activeSel));
    nco_link_props #(.HOP_DELAY(HOP_D)) i_nco_link_props (.mclk(mclk), .reset_n(reset_n),
        .hopSelA(lnk.hopSelA), .hopSelB(lnk.hopSelB), .sysref(lnk.sysref), .cfgReq(lnk.cfgReq),
        .cfgWe(lnk.cfgWe), .cfgAddr(lnk.cfgAddr), .cfgWdata(lnk.cfgWdata),
        .cfgRdata(lnk.cfgRdata));
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) sampleIn <= 24'($random(seed));
    always @(posedge mclk) smpD <= '{sampleIn[0], smpD[0]};
    // ************************************************************
    // bus tasks and comparison
    // ************************************************************
    task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wbXfer(input logic we, input logic [31:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= dat;
        do @(posedge mclk); while (wbAck !== 1'b1 && ++n < 50);
        if (n >= 50) begin
            errorCnt++;
            conclude();
        end
        wbCyc <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
        wbXfer(1'b1, adr, dat);
    endtask
    task automatic rd(input logic [31:0] adr, input logic [31:0] exp, input logic [31:0] msk);
        noteQ.push_back({msk, exp & msk});
        wbXfer(1'b0, adr, 32'h0);
    endtask
    always @(posedge mclk) begin
        logic [63:0] note;
        if (wbAck === 1'b1 && wbCyc && !wbWe) begin
            note = noteQ.size() > 0 ? noteQ.pop_front() : 64'h1;
            chkWord("read data", note[31:0], wbDatR & note[63:32]);
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rd(32'h0, 32'h0, 32'hff);
        rd(32'h4, 32'h0, 32'hffff);
        rd(32'h408, 32'h10, 32'hffff);
        rd(32'h410, 32'h0, 32'hffff_ffff);
        chkWord("mix", {16'(smpD[1] * 127 >>> 3), 16'(smpD[1] * 6 >>> 3)},
            {mixI[0], mixQ[0]});
        for (int i = 0; i < 16; i++) tw[i] = $random(seed);
        for (int i = 0; i < 16; i++) wr(32'h40 + 32'(4 * (i + (i & 8))), tw[i]);
        for (int i = 0; i < 8; i++) rd(32'h40 + 32'(4 * i), tw[i], 32'hffff_ffff);
        for (int i = 8; i < 16; i++) rd(32'h60 + 32'(4 * i), tw[i], 32'hffff);
        wr(32'h400, 32'hf);
        for (int k = 0; k < 4; k++) begin
            wr(32'h0, 32'(k << 1 | (3 - k) << 3));
            rd(32'h8, 32'((3 - k) << 2 | k), 32'hf);
        end
        wr(32'h0, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wr(32'h400, 32'(k | (3 - k) << 2));
            repeat (HOP_D + 6) @(posedge mclk);
            rd(32'h8, 32'((3 - k) << 2 | k), 32'hf);
        end
        for (int d = 0; d < 2; d++) begin
            wr(32'h4, 32'h2000 + 32'(d));
            rd(32'h40c, 32'(d), 32'h1);
            wr(32'h40c, 32'h1);
        end
        wr(32'h0, 32'h40);
        wr(32'h404, 32'h5);
        repeat (12) @(posedge mclk);
        rd(32'h8, 32'h10, 32'hff0);
        rd(32'h0, 32'h0, 32'hff);
        wr(32'h404, 32'h0);
        wr(32'h0, 32'h20);
        wr(32'h404, 32'h1);
        wr(32'h0, 32'ha0);
        wr(32'h404, 32'h0);
        wr(32'h404, 32'h1);
        repeat (8) @(posedge mclk);
        rd(32'h8, 32'h20, 32'hff0);
        rd(32'h0, 32'h80, 32'hff);
        wr(32'h404, 32'h3);
        wr(32'h0, 32'hc0);
        repeat (40) @(posedge mclk);
        rd(32'h8, 32'h30, 32'hff0);
        rd(32'h0, 32'h80, 32'hff);
        chkWord("notes left", 32'h0, 32'(noteQ.size()));
        conclude();
    end
endmodule // nco_mixer_hop_sync_tb_top
`default_nettype wire
